// ==== rtl/sar_ctrl_pkg.sv ====
// Constants, register map and carrier types for the SAR converter control block.
package sar_ctrl_pkg;
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned BURST_OSC_MHZ  = 20;
	localparam logic [3:0]  OSC_DIV        = 4'(CLK_MHZ / BURST_OSC_MHZ);
	localparam logic [4:0]  LP_TRACK_TICKS = 5'h03;
	localparam logic [6:0]  TWELVE_GROUP   = 7'h04;
	localparam logic [15:0] TWELVE_MAX     = 16'h0ffc;
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_CFG        = 8'h04;
	localparam logic [7:0]  OFF_ACC        = 8'h08;
	localparam logic [7:0]  OFF_PWR        = 8'h0c;
	localparam logic [7:0]  OFF_RESULT     = 8'h10;
	localparam logic [7:0]  OFF_GT         = 8'h14;
	localparam logic [7:0]  OFF_LT         = 8'h18;
	localparam int          CTRL_SRC_LO    = 0;
	localparam int          CTRL_WIN       = 3;
	localparam int          CTRL_BUSY      = 4;
	localparam int          CTRL_EOC       = 5;
	localparam int          CTRL_BURST     = 6;
	localparam int          CTRL_EN        = 7;
	localparam int          CTRL_LPTRK     = 8;
	localparam int          CFG_GAIN       = 0;
	localparam int          CFG_EIGHT      = 2;
	localparam int          CFG_DIV_LO     = 3;
	localparam int          ACC_RPT_LO     = 0;
	localparam int          ACC_TWELVE     = 7;
	localparam int          PWR_UP_LO      = 0;
	localparam int          PWR_TRK_LO     = 4;
	localparam logic [2:0]  SRC_SW         = 3'h0;
	localparam logic [2:0]  SRC_T0         = 3'h1;
	localparam logic [2:0]  SRC_T2         = 3'h2;
	localparam logic [2:0]  SRC_T3         = 3'h3;
	localparam logic [2:0]  SRC_EXT        = 3'h4;
	localparam logic [4:0]  RST_DIV        = 5'h1f;
	localparam logic [3:0]  RST_PWR        = 4'h4;
	localparam logic [3:0]  RST_TRK        = 4'h4;
	localparam logic [15:0] RST_GT         = 16'hffff;
	localparam logic [15:0] RST_LT         = 16'h0000;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {PH_IDLE, PH_POWERUP, PH_TRACK, PH_CONVERT} phase_t;
	typedef struct packed {
		logic t0;
		logic t2;
		logic t3;
	} timer_trig_t;
	typedef struct packed {
		logic       power;
		logic       track;
		logic       gain_half;
		logic [1:0] sub_idx;
		logic [9:0] dac_code;
	} analog_t;
	typedef struct packed {
		logic       busy;
		logic       done;
		logic [3:0] bit_idx;
		logic [9:0] trial;
		logic [9:0] result;
	} eng_state_t;
	typedef struct packed {
		phase_t      phase;
		logic [4:0]  cnt;
		logic [3:0]  osc_cnt;
		logic [4:0]  sar_cnt;
		logic [6:0]  conv_n;
		logic [15:0] acc;
		logic [15:0] result;
		logic        eng_start;
		logic        sw_req;
		logic        busy;
		logic        eoc;
		logic        win_flag;
		logic        conv_en;
		logic        burst;
		logic        lp_track;
		logic [2:0]  src;
		logic [4:0]  sar_div;
		logic        eight_bit;
		logic        gain;
		logic        twelve;
		logic [2:0]  rpt;
		logic [3:0]  pwr_time;
		logic [3:0]  trk_time;
		logic [15:0] gt_lim;
		logic [15:0] lt_lim;
		logic        pin_s1;
		logic        pin_s2;
		logic        pin_s3;
		logic        comp_s1;
		logic        comp_s2;
		logic        aw_have;
		logic [7:0]  aw_addr;
		logic        w_have;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} ctl_state_t;
endpackage

// ==== rtl/sar_engine.sv ====
// Successive-approximation bit search, one trial per SAR clock tick.
`timescale 1ns/1ps
`default_nettype none
module sar_engine
	import sar_ctrl_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       sar_tick,
	input  wire logic       start,
	input  wire logic       eight_bit,
	input  wire logic       comp_high,
	output logic [9:0]      dac_code,
	output logic            done,
	output logic [9:0]      result
);
	eng_state_t s;
	eng_state_t next_s;
	logic [9:0] kept;
	logic [3:0] stop_idx;

	// Stopping two bits early leaves the two least bits at zero.
	assign stop_idx = eight_bit ? 4'h2 : 4'h0;

	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		kept = s.trial;
		if (!comp_high)
			kept[s.bit_idx] = 1'b0;
		if (start)
		begin
			next_s.busy = 1'b1;
			next_s.bit_idx = 4'h9;
			next_s.trial = 10'h200;
		end
		else if (s.busy && sar_tick)
		begin
			if (s.bit_idx == stop_idx)
			begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
				next_s.result = kept;
				next_s.trial = kept;
			end
			else
			begin
				next_s.bit_idx = s.bit_idx - 4'h1;
				next_s.trial = kept;
				next_s.trial[s.bit_idx - 4'h1] = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign dac_code = s.trial;
	assign done = s.done;
	assign result = s.result;
endmodule
`default_nettype wire

// ==== rtl/sar_track_burst_ctl.sv ====
// Track, burst, accumulate and register control for the SAR converter.
`timescale 1ns/1ps
`default_nettype none
module sar_track_burst_ctl
	import sar_ctrl_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire timer_trig_t timers,
	input  wire logic        ext_convert_start_pin,
	input  wire logic        low_power_standby,
	input  wire logic        comp_high,
	output analog_t          ana
);
	ctl_state_t  s;
	ctl_state_t  next_s;
	logic        base_tick;
	logic        sar_tick;
	logic        start_evt;
	logic        ext_gated;
	logic        idle_track;
	logic        twelve_on;
	logic        last_conv;
	logic        eng_done;
	logic [9:0]  eng_result;
	logic [9:0]  dac_code;
	logic [6:0]  target;
	logic [15:0] sum;
	logic [15:0] final_val;
	logic        wr_go;

	function automatic logic [6:0] rpt_target(input logic [2:0] code, input logic twelve);
		logic [6:0] n;
		case (code)
			3'h1: n = 7'h04;
			3'h2: n = 7'h08;
			3'h3: n = 7'h10;
			3'h4: n = 7'h20;
			3'h5: n = 7'h40;
			default: n = 7'h01;
		endcase
		if (twelve && n < TWELVE_GROUP)
			n = TWELVE_GROUP;
		return n;
	endfunction

	function automatic logic [4:0] track_len(input logic burst, input logic lp,
		input logic [3:0] trk);
		logic [4:0] t;
		t = burst ? {1'b0, trk} : 5'h00;
		if (lp)
			t = t + LP_TRACK_TICKS;
		return t;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// The burst clock is modelled as an enable, so a burst still needs system clocks.
	assign base_tick = !s.burst || (s.osc_cnt == OSC_DIV - 4'h1);
	assign sar_tick = base_tick && (s.sar_cnt >= s.sar_div);
	assign ext_gated = s.lp_track && !s.burst && (s.src == SRC_EXT);
	assign target = rpt_target(s.rpt, s.twelve);
	assign twelve_on = s.twelve && s.burst && (target[1:0] == 2'h0);
	assign last_conv = (s.conv_n + 7'h01) == target;
	assign sum = s.acc + {6'h00, eng_result};
	assign final_val = (s.eight_bit && target == 7'h01) ? {eng_result[9:2], 8'h00} : sum;
	assign wr_go = s.aw_have && s.w_have && !s.bvalid;

	always_comb
	begin
		case (s.src)
			SRC_SW: start_evt = s.sw_req;
			SRC_T0: start_evt = timers.t0;
			SRC_T2: start_evt = timers.t2;
			SRC_T3: start_evt = timers.t3;
			SRC_EXT: start_evt = s.pin_s2 && !s.pin_s3;
			default: start_evt = 1'b0;
		endcase
	end

	// Idle tracking: always in the default mode, pin-low only in gated mode.
	assign idle_track = (!s.lp_track && !s.burst) || (ext_gated && !s.pin_s2);

	always_comb
	begin
		ana.power = s.burst ? (s.conv_en || s.phase != PH_IDLE) : s.conv_en;
		ana.track = !low_power_standby && ana.power
			&& (s.phase == PH_TRACK || (s.phase == PH_IDLE && idle_track));
		ana.gain_half = s.gain;
		ana.sub_idx = twelve_on ? s.conv_n[1:0] : 2'h0;
		ana.dac_code = dac_code;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_s = s;
		next_s.sw_req = 1'b0;
		next_s.eng_start = 1'b0;
		next_s.pin_s1 = ext_convert_start_pin;
		next_s.pin_s2 = s.pin_s1;
		next_s.pin_s3 = s.pin_s2;
		next_s.comp_s1 = comp_high;
		next_s.comp_s2 = s.comp_s1;
		// Restarting both dividers with each conversion lets the comparator settle first.
		// Outside burst this still needs a SAR divide of at least two.
		next_s.osc_cnt = (s.eng_start || s.osc_cnt == OSC_DIV - 4'h1) ? 4'h0 : s.osc_cnt + 4'h1;
		if (sar_tick || s.eng_start)
			next_s.sar_cnt = 5'h00;
		else if (base_tick)
			next_s.sar_cnt = s.sar_cnt + 5'h01;

		if (s_axi_awvalid && s_axi_awready)
		begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_s.w_have = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		if (wr_go)
		begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.aw_addr)
				OFF_CTRL:
				begin
					if (s.wstrb[0])
					begin
						next_s.src = s.wdata[CTRL_SRC_LO +: 3];
						next_s.win_flag = s.win_flag & s.wdata[CTRL_WIN];
						next_s.eoc = s.eoc & s.wdata[CTRL_EOC];
						next_s.burst = s.wdata[CTRL_BURST];
						next_s.conv_en = s.wdata[CTRL_EN];
						next_s.sw_req = s.wdata[CTRL_BUSY]
							&& s.wdata[CTRL_SRC_LO +: 3] == SRC_SW;
					end
					if (s.wstrb[1])
						next_s.lp_track = s.wdata[CTRL_LPTRK];
				end
				OFF_CFG:
					if (s.wstrb[0])
					begin
						next_s.gain = s.wdata[CFG_GAIN];
						next_s.eight_bit = s.wdata[CFG_EIGHT];
						next_s.sar_div = s.wdata[CFG_DIV_LO +: 5];
					end
				OFF_ACC:
					if (s.wstrb[0])
					begin
						next_s.rpt = s.wdata[ACC_RPT_LO +: 3];
						next_s.twelve = s.wdata[ACC_TWELVE];
					end
				OFF_PWR:
					if (s.wstrb[0])
					begin
						next_s.pwr_time = s.wdata[PWR_UP_LO +: 4];
						next_s.trk_time = s.wdata[PWR_TRK_LO +: 4];
					end
				OFF_GT:
				begin
					if (s.wstrb[0])
						next_s.gt_lim[7:0] = s.wdata[7:0];
					if (s.wstrb[1])
						next_s.gt_lim[15:8] = s.wdata[15:8];
				end
				OFF_LT:
				begin
					if (s.wstrb[0])
						next_s.lt_lim[7:0] = s.wdata[7:0];
					if (s.wstrb[1])
						next_s.lt_lim[15:8] = s.wdata[15:8];
				end
				OFF_RESULT: next_s.bresp = RESP_OKAY;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end

		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			case (s_axi_araddr)
				OFF_CTRL: next_s.rdata = {23'h000000, s.lp_track, s.conv_en, s.burst,
					s.eoc, s.busy, s.win_flag, s.src};
				OFF_CFG: next_s.rdata = {24'h000000, s.sar_div, s.eight_bit, 1'b0, s.gain};
				OFF_ACC: next_s.rdata = {24'h000000, s.twelve, 4'h0, s.rpt};
				OFF_PWR: next_s.rdata = {24'h000000, s.trk_time, s.pwr_time};
				OFF_RESULT: next_s.rdata = {16'h0000, s.result};
				OFF_GT: next_s.rdata = {16'h0000, s.gt_lim};
				OFF_LT: next_s.rdata = {16'h0000, s.lt_lim};
				default:
				begin
					next_s.rdata = 32'h00000000;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Hardware sets come after the bus clears so that a set in the same cycle wins.
		unique case (s.phase)
			PH_IDLE:
				// Starts are taken only here; closer spacing in burst is not queued.
				if (start_evt)
				begin
					next_s.busy = 1'b1;
					if (s.conv_n == 7'h00)
						next_s.acc = 16'h0000;
					if (s.burst && !s.conv_en)
					begin
						next_s.phase = PH_POWERUP;
						next_s.cnt = {1'b0, s.pwr_time};
					end
					else if (ext_gated)
					begin
						next_s.phase = PH_CONVERT;
						next_s.eng_start = 1'b1;
					end
					else
					begin
						next_s.phase = PH_TRACK;
						next_s.cnt = track_len(s.burst, s.lp_track, s.trk_time);
					end
				end
			PH_POWERUP:
				if (s.cnt == 5'h00)
				begin
					next_s.phase = PH_TRACK;
					next_s.cnt = track_len(s.burst, s.lp_track, s.trk_time);
				end
				else if (sar_tick)
					next_s.cnt = s.cnt - 5'h01;
			PH_TRACK:
				if (s.cnt == 5'h00)
				begin
					next_s.phase = PH_CONVERT;
					next_s.eng_start = 1'b1;
				end
				else if (sar_tick)
					next_s.cnt = s.cnt - 5'h01;
			PH_CONVERT:
				if (eng_done)
				begin
					next_s.acc = sum;
					if (last_conv)
					begin
						next_s.result = final_val;
						next_s.eoc = 1'b1;
						if (final_val > s.gt_lim && final_val < s.lt_lim)
							next_s.win_flag = 1'b1;
						next_s.busy = 1'b0;
						next_s.conv_n = 7'h00;
						next_s.phase = PH_IDLE;
					end
					else if (s.burst)
					begin
						next_s.conv_n = s.conv_n + 7'h01;
						next_s.phase = PH_TRACK;
						next_s.cnt = track_len(s.burst, s.lp_track, s.trk_time);
					end
					else
					begin
						next_s.conv_n = s.conv_n + 7'h01;
						next_s.busy = 1'b0;
						next_s.phase = PH_IDLE;
					end
				end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
			s.sar_div <= RST_DIV;
			s.pwr_time <= RST_PWR;
			s.trk_time <= RST_TRK;
			s.gt_lim <= RST_GT;
			s.lt_lim <= RST_LT;
		end
		else
			s <= next_s;
	end

	sar_engine u_engine (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.sar_tick  (sar_tick),
		.start     (s.eng_start),
		.eight_bit (s.eight_bit),
		.comp_high (s.comp_s2),
		.dac_code  (dac_code),
		.done      (eng_done),
		.result    (eng_result)
	);

	assign s_axi_awready = !s.aw_have && !s.bvalid;
	assign s_axi_wready = !s.w_have && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence burst_cold_start;
		s.phase == PH_IDLE && start_evt && s.burst && !s.conv_en;
	endsequence
	sequence warm_start;
		s.phase == PH_IDLE && start_evt && s.burst && s.conv_en;
	endsequence

	cont_track_a: assert property ((s.phase == PH_IDLE && !s.lp_track && !s.burst
		&& s.conv_en && !low_power_standby) |-> ana.track)
		else $error("continuous tracking lost while idle");
	lp_three_a: assert property ((s.phase == PH_IDLE && start_evt && !s.burst
		&& s.lp_track && s.src != SRC_EXT) |=> (s.phase == PH_TRACK && s.cnt == 5'h03))
		else $error("low-power tracking not three SAR clocks");
	pin_gate_a: assert property ((s.phase == PH_IDLE && ext_gated && s.conv_en
		&& !low_power_standby) |-> (ana.track == !s.pin_s2))
		else $error("tracking does not follow pin level");
	standby_off_a: assert property (low_power_standby |-> !ana.track)
		else $error("tracking during standby");
	cold_power_a: assert property (burst_cold_start |=> s.phase == PH_POWERUP
		##0 s.cnt == {1'b0, $past(s.pwr_time)})
		else $error("cold burst start skipped power-up");
	warm_track_a: assert property (warm_start |=> s.phase == PH_TRACK)
		else $error("warm burst start did not track at once");
	burst_chain_a: assert property ((s.phase == PH_CONVERT && eng_done && s.burst
		&& !last_conv) |=> (s.phase == PH_TRACK && s.busy && !$rose(s.eoc)))
		else $error("burst did not chain next conversion");
	eoc_series_a: assert property ($rose(s.eoc) |-> $past(last_conv)
		&& $past(s.phase) == PH_CONVERT && !s.busy)
		else $error("end flag before series complete");
	eight_low_a: assert property (($rose(s.eoc) && s.eight_bit
		&& target == 7'h01) |-> s.result[7:0] == 8'h00)
		else $error("eight-bit low byte not zero");
	twelve_max_a: assert property (($rose(s.eoc) && twelve_on
		&& target == TWELVE_GROUP) |-> s.result <= TWELVE_MAX)
		else $error("twelve-bit result above 4092");
endmodule
`default_nettype wire

// ==== tb/analog_front_model.sv ====
// Behavioural comparator and reference ladder that face the converter control block.
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
	import sar_ctrl_pkg::*;
(
	input  wire logic        aclk,
	input  wire analog_t     ana,
	input  wire logic [11:0] vin,
	output logic             comp_high
);
	logic [12:0] level;
	logic        junk = 1'b0;
	////////////////////////////////////////////////////////////////////////////////
	// An unpowered comparator gives no valid answer, so it chatters instead of holding a level.
	always_ff @(posedge aclk)
		junk <= ~junk;
	// Input sits between codes, so only a twelve-bit sub-step offset can reach a tie, and a tie keeps the bit.
	always_comb
	begin
		level = ana.gain_half ? {2'h0, vin[11:1]} : {1'h0, vin};
		if (ana.power)
			comp_high = (level + 13'(ana.sub_idx)) >= {1'h0, ana.dac_code, 2'h0};
		else
			comp_high = junk;
	end
endmodule
`default_nettype wire

// ==== tb/sar_track_burst_ctl_bench.sv ====
// Register-level bench for the SAR track, burst and accumulate control block.
`timescale 1ns/1ps
`default_nettype none
module sar_track_burst_ctl_bench
	import sar_ctrl_pkg::*;
;
	logic        aclk, aresetn, awready, wready, bvalid, arready, rvalid;
	logic        awvalid, wvalid, bready, arvalid, rready, pin, standby, comp_high;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d, c;
	logic [1:0]  bresp, rresp, r;
	logic [11:0] vin;
	timer_trig_t timers;
	analog_t     ana;
	int          fail_count, compares, i, k;
	logic [31:0] rst_tab [8] = '{32'h0, 32'hf8, 32'h0, 32'h44, 32'h0, 32'hffff, 32'h0, 32'h0};
	int          counts [6] = '{1, 4, 8, 16, 32, 64};
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	sar_track_burst_ctl sar_track_burst_ctl_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.timers(timers), .ext_convert_start_pin(pin), .low_power_standby(standby),
		.comp_high(comp_high), .ana(ana));
	analog_front_model analog_front_model_i (.aclk(aclk), .ana(ana), .vin(vin),
		.comp_high(comp_high));
	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("counts compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		summarize();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD time=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	// Each access ends one edge after its answer so no strobe is driven twice in a step.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		r = bresp;
		if (n == 100)
			hang();
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		if (n == 100)
			hang();
		@(posedge aclk);
	endtask
	task automatic wait_bit(input int b, input logic v);
		int n;
		for (n = 0; n < 8000; n++)
		begin
			rd(OFF_CTRL);
			if (d[b] === v)
				break;
		end
		if (n == 8000)
			hang();
	endtask
	// Starts a series from the chosen source, checks the result, then clears the flags.
	task automatic run(input logic [31:0] cw, input int src, input logic [31:0] exp);
		wr(OFF_CTRL, cw);
		if (src >= 1 && src <= 3)
		begin
			timers <= timer_trig_t'(3'h4 >> (src - 1));
			@(posedge aclk);
			timers <= '0;
		end
		if (src == 4)
			pin <= 1'b1;
		wait_bit(CTRL_EOC, 1'b1);
		c = d;
		pin <= 1'b0;
		chk({31'h0, c[CTRL_BUSY]}, 32'h0);
		rd(OFF_RESULT);
		chk(d, exp);
		wr(OFF_CTRL, cw & 32'h1c7);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, pin, standby} = '0;
		{awaddr, araddr, wdata, timers} = '0;
		vin = 12'ha97;
		aresetn = 1'b0;
		fail_count = 0;
		compares = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 8; i++)
		begin
			rd(8'(i * 4));
			chk(d, rst_tab[i]);
			chk({30'h0, r}, {30'h0, (i == 7) ? RESP_SLVERR : RESP_OKAY});
		end
		wr(OFF_RESULT, 32'h5);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		wr(8'h1c, 32'h5);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(OFF_RESULT);
		chk(d, 32'h0);
		$display("test reset and map done");
		wr(OFF_CFG, 32'h18);
		wr(OFF_PWR, 32'h11);
		wr(OFF_GT, 32'h0);
		wr(OFF_LT, 32'hffff);
		run(32'h90, 0, 32'h2a5);
		chk({31'h0, c[CTRL_WIN]}, 32'h1);
		chk({31'h0, ana.track}, 32'h1);
		standby <= 1'b1;
		repeat (2) @(posedge aclk);
		chk({31'h0, ana.track}, 32'h0);
		standby <= 1'b0;
		for (k = 1; k < 5; k++)
			run(32'h80 | k, k, 32'h2a5);
		run(32'h190, 0, 32'h2a5);
		run(32'h184, 4, 32'h2a5);
		wr(OFF_CFG, 32'h1c);
		run(32'h90, 0, 32'ha900);
		wr(OFF_CFG, 32'h19);
		run(32'h90, 0, 32'h152);
		$display("test single conversions done");
		wr(OFF_CFG, 32'h18);
		wr(OFF_ACC, 32'h1);
		for (k = 0; k < 2; k++)
		begin
			for (i = 0; i < 3; i++)
			begin
				wr(OFF_CTRL, 32'h90);
				wait_bit(CTRL_BUSY, 1'b0);
				chk(d & 32'h28, 32'h0);
			end
			run(32'h90, 0, 32'ha94);
			chk({31'h0, c[CTRL_WIN]}, 32'h1);
		end
		$display("test non-burst repeat done");
		wr(OFF_CFG, 32'h0);
		for (i = 0; i < 6; i++)
		begin
			wr(OFF_ACC, 32'(i));
			run(32'h50, 0, 32'(counts[i] * 32'h2a5));
			chk({31'h0, ana.power}, 32'h0);
		end
		wr(OFF_ACC, 32'h1);
		run(32'hd0, 0, 32'ha94);
		chk({31'h0, ana.power}, 32'h1);
		run(32'h150, 0, 32'ha94);
		$display("test burst done");
		wr(OFF_ACC, 32'h81);
		vin <= 12'habd;
		run(32'h50, 0, 32'habd);
		vin <= 12'hfff;
		run(32'h50, 0, 32'hffc);
		wr(OFF_ACC, 32'h83);
		vin <= 12'habd;
		run(32'h50, 0, 32'h2af4);
		$display("test twelve-bit done");
		summarize();
	end
endmodule
`default_nettype wire
